// file: area_protection.v
// Area protection and security sessions for a dual-interface tag memory.
// Assumes commands arrive already decoded and CRC-checked, and that memory data
// is fetched downstream for each granted block item leaving the output buffer.
//
// Behaviour
// - standard read: byte fields, up to 256 blocks
// - cross-area multi-block read aborts with 0Fh
// - standard commands never reach blocks above FFh
// - extended read: two-byte fields, bounded by memory
// - status queries 2Ch standard, 3Ch extended
// - four contiguous areas, eight-block granularity
// - area one starts at zero, four ends last
// - each non-empty area at least eight blocks
// - after reset, one area spans memory
// - per-area contactless protection under user passwords
// - host protection per area, one host password
// - area one readable; blocks zero, one lockable
// - correct user password opens matching user session
// - user session writes only its own password
// - password zero opens configuration session
// - wrong number or value closes user session
// - other number or wrong zero closes configuration
// - correct host password opens host session
// - host password write needs open host session
// - wrong host password closes; status bit shown
// - all passwords 64 bits, reset to zero
// - write password command code B1h
// - present password command code B3h
// - area end n means block 8n+7
`include "area_protection_defines.vh"

module area_protection #(
  parameter MEM_BLOCKS = 2048,
  parameter END_W = 8
) (
  input wire clk,
  input wire rstn,
  input wire cmd_valid,
  output wire cmd_ready,
  input wire [7:0] cmd_code,
  input wire cmd_option,
  input wire [15:0] cmd_first,
  input wire [15:0] cmd_count,
  input wire [7:0] cmd_pwd_num,
  input wire [63:0] cmd_pwd,
  output wire out_valid,
  input wire out_ready,
  output wire [15:0] out_block,
  output wire [7:0] out_status,
  output wire out_has_status,
  output wire out_error,
  output wire out_last,
  input wire host_present_valid,
  input wire [63:0] host_present_pwd,
  input wire host_write_valid,
  input wire [63:0] host_write_pwd,
  output reg host_write_rejected,
  output wire host_session_open_status,
  input wire cfg_wr_valid,
  input wire cfg_wr_from_host,
  input wire [3:0] cfg_wr_sel,
  input wire [7:0] cfg_wr_data,
  output reg cfg_wr_rejected,
  output reg rf_pwd_rejected,
  output wire rf_user_session_open,
  output wire rf_cfg_session_open,
  input wire [15:0] rf_wr_block,
  output wire rf_wr_allowed,
  input wire [15:0] host_block,
  input wire host_is_write,
  output wire host_access_allowed,
  output wire [END_W-1:0] area_one_end,
  output wire [END_W-1:0] area_two_end,
  output wire [END_W-1:0] area_three_end
);

  localparam integer LAST_END_I = MEM_BLOCKS / `AREA_GRAIN - 1;
  localparam [END_W-1:0] LAST_END = LAST_END_I[END_W-1:0];
  localparam integer LAST_BLK_I = MEM_BLOCKS - 1;
  localparam [16:0] LAST_BLK = LAST_BLK_I[16:0];
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_RUN = 3'b010;
  localparam [2:0] ST_ERR = 3'b100;
  localparam ITEM_W = 28;

  // ************************************************************
  // Configuration and session state
  // ************************************************************
  reg [END_W-1:0] end1_q, end2_q, end3_q;
  reg [3:0] rf_prot_q [0:3];
  reg [7:0] host_area_protection_q;
  reg [1:0] block_lock_q;
  reg [63:0] rf_pwd_q [0:3];
  reg [63:0] host_pwd_q;
  reg user_open_q;
  reg [1:0] user_num_q;
  reg cfg_open_q;
  reg host_open_q;

  assign area_one_end = end1_q;
  assign area_two_end = end2_q;
  assign area_three_end = end3_q;
  assign host_session_open_status = host_open_q;
  assign rf_user_session_open = user_open_q;
  assign rf_cfg_session_open = cfg_open_q;

  // Area of a block from the three end settings; area four takes the rest
  function [1:0] area_of;
    input [15:0] b;
    input [END_W-1:0] e1, e2, e3;
    reg [12:0] g;
    begin
      g = b[15:`AREA_SHIFT];
      if (g <= {{(13-END_W){1'b0}}, e1}) begin
        area_of = 2'd0;
      end else if (g <= {{(13-END_W){1'b0}}, e2}) begin
        area_of = 2'd1;
      end else if (g <= {{(13-END_W){1'b0}}, e3}) begin
        area_of = 2'd2;
      end else begin
        area_of = 2'd3;
      end
    end
  endfunction

  // Ends must rise by a whole grain, or sit together at the end of memory
  function layout_ok;
    input [END_W-1:0] e1, e2, e3;
    begin
      layout_ok = (e3 <= LAST_END) &&
        ((e1 < e2) || (e1 == LAST_END && e2 == LAST_END)) &&
        ((e2 < e3) || (e2 == LAST_END && e3 == LAST_END));
    end
  endfunction

  // Contactless read or write right of an area under the current session
  function rf_right;
    input [3:0] prot;
    input is_write;
    input uopen;
    input [1:0] unum;
    reg sess;
    begin
      sess = uopen && (prot[1:0] != 2'd0) && (unum == prot[1:0]);
      case (prot[3:2])
        `MODE_R_ALWAYS_W_SESS: rf_right = is_write ? sess : 1'b1;
        `MODE_RW_ALWAYS: rf_right = 1'b1;
        `MODE_RW_SESS: rf_right = sess;
        `MODE_R_SESS_W_NEVER: rf_right = is_write ? 1'b0 : sess;
        default: rf_right = 1'b0;
      endcase
    end
  endfunction

  function locked_blk;
    input [15:0] b;
    input [1:0] lk;
    begin
      locked_blk = (b == 16'h0000 && lk[0]) || (b == 16'h0001 && lk[1]);
    end
  endfunction

  // ************************************************************
  // Combinational access checks
  // ************************************************************
  wire [1:0] wr_area = area_of(rf_wr_block, end1_q, end2_q, end3_q);
  assign rf_wr_allowed = rf_right(rf_prot_q[wr_area], 1'b1, user_open_q, user_num_q) &&
    !locked_blk(rf_wr_block, block_lock_q);

  wire [1:0] h_area = area_of(host_block, end1_q, end2_q, end3_q);
  wire h_rd_prot = host_area_protection_q[{h_area, 1'b0}] && (h_area != 2'd0);
  wire h_wr_prot = host_area_protection_q[{h_area, 1'b1}];
  assign host_access_allowed = host_open_q || (host_is_write ? !h_wr_prot : !h_rd_prot);

  // ************************************************************
  // Command decode
  // ************************************************************
  wire is_std = (cmd_code == `CMD_READ_MULTI) || (cmd_code == `CMD_FAST_READ_MULTI) ||
    (cmd_code == `CMD_GET_MULTI_SS);
  wire is_ext = (cmd_code == `CMD_EXT_READ_MULTI) || (cmd_code == `CMD_FAST_EXT_READ_MULTI) ||
    (cmd_code == `CMD_EXT_GET_MULTI_SS);
  wire is_ss = (cmd_code == `CMD_GET_MULTI_SS) || (cmd_code == `CMD_EXT_GET_MULTI_SS);
  wire [15:0] first = is_std ? {8'h00, cmd_first[7:0]} : cmd_first;
  wire [15:0] count = is_std ? {8'h00, cmd_count[7:0]} : cmd_count;
  wire [16:0] last_sum = {1'b0, first} + {1'b0, count};
  wire [15:0] last_blk = last_sum[15:0];
  wire out_of_range = (is_std && last_sum > `STD_MAX_BLK) || (last_sum > LAST_BLK);
  wire [1:0] first_area = area_of(first, end1_q, end2_q, end3_q);
  wire cross_area = !is_ss && (first_area != area_of(last_blk, end1_q, end2_q, end3_q));
  wire read_denied = !is_ss && (first_area != 2'd0) &&
    !rf_right(rf_prot_q[first_area], 1'b0, user_open_q, user_num_q);

  // ************************************************************
  // Sequencer
  // ************************************************************
  reg [2:0] state_q;
  reg [15:0] cur_q, remain_q;
  reg [7:0] err_q;
  reg with_status_q;
  wire buf_in_ready;
  reg buf_in_valid;
  reg [ITEM_W-1:0] buf_in_data;
  wire [1:0] cur_area = area_of(cur_q, end1_q, end2_q, end3_q);
  wire [7:0] cur_status = {1'b0, cur_area, locked_blk(cur_q, block_lock_q),
    rf_prot_q[cur_area]};

  assign cmd_ready = (state_q == ST_IDLE);
  wire take = cmd_valid && cmd_ready;

  always @* begin
    buf_in_valid = 1'b0;
    buf_in_data = {ITEM_W{1'b0}};
    case (state_q)
      ST_RUN: begin
        buf_in_valid = 1'b1;
        buf_in_data = {with_status_q, 1'b0, remain_q == 16'h0000, 1'b0, cur_status, cur_q};
      end
      ST_ERR: begin
        buf_in_valid = 1'b1;
        buf_in_data = {2'b00, 1'b1, 1'b1, err_q, cur_q};
      end
      default: begin
        buf_in_valid = 1'b0;
      end
    endcase
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      cur_q <= 16'h0000;
      remain_q <= 16'h0000;
      err_q <= 8'h00;
      with_status_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (take && (is_std || is_ext)) begin
            cur_q <= first;
            remain_q <= count;
            with_status_q <= is_ss || cmd_option;
            if (out_of_range) begin
              err_q <= `ERR_RANGE;
              state_q <= ST_ERR;
            end else if (cross_area) begin
              err_q <= `ERR_CROSS_AREA;
              state_q <= ST_ERR;
            end else if (read_denied) begin
              err_q <= `ERR_READ_PROT;
              state_q <= ST_ERR;
            end else begin
              state_q <= ST_RUN;
            end
          end
        end
        ST_RUN: begin
          if (buf_in_ready) begin
            if (remain_q == 16'h0000) begin
              state_q <= ST_IDLE;
            end else begin
              cur_q <= cur_q + 16'h0001;
              remain_q <= remain_q - 16'h0001;
            end
          end
        end
        ST_ERR: begin
          if (buf_in_ready) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // Two-entry output buffer
  // ************************************************************
  // Two entries let the sequencer push during a one-cycle stall; it then waits one cycle while both entries are full
  reg [ITEM_W-1:0] buf_mem_q [0:1];
  reg buf_wr_q, buf_rd_q;
  reg [1:0] buf_cnt_q;
  assign buf_in_ready = (buf_cnt_q != 2'd2);
  assign out_valid = (buf_cnt_q != 2'd0);
  wire buf_push = buf_in_valid && buf_in_ready;
  wire buf_pop = out_valid && out_ready;
  wire [ITEM_W-1:0] head = buf_mem_q[buf_rd_q];
  assign out_block = head[15:0];
  assign out_status = head[23:16];
  assign out_error = head[24];
  assign out_last = head[25];
  assign out_has_status = head[27];

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      buf_mem_q[0] <= {ITEM_W{1'b0}};
      buf_mem_q[1] <= {ITEM_W{1'b0}};
      buf_wr_q <= 1'b0;
      buf_rd_q <= 1'b0;
      buf_cnt_q <= 2'd0;
    end else begin
      if (buf_push) begin
        buf_mem_q[buf_wr_q] <= buf_in_data;
        buf_wr_q <= ~buf_wr_q;
      end
      if (buf_pop) begin
        buf_rd_q <= ~buf_rd_q;
      end
      if (buf_push && !buf_pop) begin
        buf_cnt_q <= buf_cnt_q + 2'd1;
      end else if (buf_pop && !buf_push) begin
        buf_cnt_q <= buf_cnt_q - 2'd1;
      end
    end
  end

  // ************************************************************
  // Sessions, passwords and configuration
  // ************************************************************
  wire pnum_ok = (cmd_pwd_num[7:2] == 6'd0);
  wire [1:0] pnum = cmd_pwd_num[1:0];
  wire pwd_match = pnum_ok && (rf_pwd_q[pnum] == cmd_pwd);
  wire cfg_allowed = cfg_wr_from_host ? host_open_q : cfg_open_q;
  wire [END_W-1:0] new_end = cfg_wr_data[END_W-1:0];
  reg cfg_ok;
  always @* begin
    case (cfg_wr_sel)
      `CFG_AREA_ONE_END: cfg_ok = layout_ok(new_end, end2_q, end3_q);
      `CFG_AREA_TWO_END: cfg_ok = layout_ok(end1_q, new_end, end3_q);
      `CFG_AREA_THREE_END: cfg_ok = layout_ok(end1_q, end2_q, new_end);
      default: cfg_ok = 1'b1;
    endcase
  end
  integer i;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      end1_q <= LAST_END;
      end2_q <= LAST_END;
      end3_q <= LAST_END;
      for (i = 0; i < 4; i = i + 1) begin
        rf_prot_q[i] <= `PROT_RESET;
        rf_pwd_q[i] <= `PWD_RESET;
      end
      host_area_protection_q <= `HOST_PROT_RESET;
      block_lock_q <= 2'b00;
      host_pwd_q <= `PWD_RESET;
      user_open_q <= 1'b0;
      user_num_q <= 2'd0;
      cfg_open_q <= 1'b0;
      host_open_q <= 1'b0;
      host_write_rejected <= 1'b0;
      cfg_wr_rejected <= 1'b0;
      rf_pwd_rejected <= 1'b0;
    end else begin
      host_write_rejected <= 1'b0;
      cfg_wr_rejected <= 1'b0;
      rf_pwd_rejected <= 1'b0;
      if (take && cmd_code == `CMD_PRESENT_PWD) begin
        cfg_open_q <= pwd_match && (pnum == 2'd0);
        user_open_q <= pwd_match && (pnum != 2'd0);
        user_num_q <= pnum;
        rf_pwd_rejected <= !pwd_match;
      end
      if (take && cmd_code == `CMD_WRITE_PWD) begin
        if (pnum_ok && ((pnum == 2'd0) ? cfg_open_q : (user_open_q && user_num_q == pnum))) begin
          rf_pwd_q[pnum] <= cmd_pwd;
        end else begin
          rf_pwd_rejected <= 1'b1;
        end
      end
      if (host_present_valid) begin
        host_open_q <= (host_present_pwd == host_pwd_q);
      end else if (host_write_valid) begin
        if (host_open_q) begin
          host_pwd_q <= host_write_pwd;
        end else begin
          host_write_rejected <= 1'b1;
        end
      end
      if (cfg_wr_valid) begin
        if (cfg_allowed && cfg_ok) begin
          case (cfg_wr_sel)
            `CFG_AREA_ONE_END: end1_q <= new_end;
            `CFG_AREA_TWO_END: end2_q <= new_end;
            `CFG_AREA_THREE_END: end3_q <= new_end;
            `CFG_RF_PROT_1: rf_prot_q[0] <= cfg_wr_data[3:0];
            `CFG_RF_PROT_2: rf_prot_q[1] <= cfg_wr_data[3:0];
            `CFG_RF_PROT_3: rf_prot_q[2] <= cfg_wr_data[3:0];
            `CFG_RF_PROT_4: rf_prot_q[3] <= cfg_wr_data[3:0];
            `CFG_HOST_PROT: host_area_protection_q <= cfg_wr_data;
            `CFG_BLOCK_LOCK: block_lock_q <= block_lock_q | cfg_wr_data[1:0];
            default: cfg_wr_rejected <= 1'b1;
          endcase
        end else begin
          cfg_wr_rejected <= 1'b1;
        end
      end
    end
  end

endmodule // area_protection

// file: area_protection_defines.vh
// Command codes, answer codes, field layouts and reset values for area_protection.
// Assumes the includer uses these names only; nothing here drives logic.
`ifndef AREA_PROTECTION_DEFINES_VH
`define AREA_PROTECTION_DEFINES_VH

// ************************************************************
// Contactless command codes
// ************************************************************
`define CMD_READ_MULTI 8'h23
`define CMD_FAST_READ_MULTI 8'hC3
`define CMD_EXT_READ_MULTI 8'h33
`define CMD_FAST_EXT_READ_MULTI 8'hC5
`define CMD_GET_MULTI_SS 8'h2C
`define CMD_EXT_GET_MULTI_SS 8'h3C
`define CMD_WRITE_PWD 8'hB1
`define CMD_PRESENT_PWD 8'hB3

// ************************************************************
// Answer codes
// ************************************************************
`define ERR_CROSS_AREA 8'h0F
// Plain default values, chosen for this block
`define ERR_RANGE 8'h10
`define ERR_READ_PROT 8'h15

// ************************************************************
// Geometry and widths
// ************************************************************
`define PWD_W 64
`define PWD_RESET 64'h0000000000000000
`define STD_MAX_BLK 17'h000FF
`define AREA_GRAIN 8
`define AREA_SHIFT 3

// ************************************************************
// Configuration write selectors
// ************************************************************
`define CFG_AREA_ONE_END 4'h1
`define CFG_AREA_TWO_END 4'h2
`define CFG_AREA_THREE_END 4'h3
`define CFG_RF_PROT_1 4'h4
`define CFG_RF_PROT_2 4'h5
`define CFG_RF_PROT_3 4'h6
`define CFG_RF_PROT_4 4'h7
`define CFG_HOST_PROT 4'h8
`define CFG_BLOCK_LOCK 4'h9

// ************************************************************
// Contactless protection field: [1:0] password select, [3:2] access mode
// ************************************************************
`define PROT_RESET 4'h0
`define HOST_PROT_RESET 8'h00
`define MODE_R_ALWAYS_W_SESS 2'h0
`define MODE_RW_ALWAYS 2'h1
`define MODE_RW_SESS 2'h2
`define MODE_R_SESS_W_NEVER 2'h3

`endif

// file: area_protection_monitor.sv
// Concurrent checks on the ports of area_protection.
// Assumes a single clock clk and the asynchronous active-low reset rstn.
module area_protection_monitor #(
  parameter int END_W = 8
) (
  input wire clk,
  input wire rstn,
  input wire cmd_valid,
  input wire cmd_ready,
  input wire [7:0] cmd_code,
  input wire [7:0] cmd_pwd_num,
  input wire out_valid,
  input wire out_ready,
  input wire [15:0] out_block,
  input wire [7:0] out_status,
  input wire out_has_status,
  input wire out_error,
  input wire out_last,
  input wire host_present_valid,
  input wire host_write_valid,
  input wire host_write_rejected,
  input wire host_session_open_status,
  input wire cfg_wr_valid,
  input wire cfg_wr_from_host,
  input wire cfg_wr_rejected,
  input wire rf_pwd_rejected,
  input wire rf_user_session_open,
  input wire rf_cfg_session_open,
  input wire [END_W-1:0] area_one_end
);
  wire take;
  assign take = cmd_valid && cmd_ready;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // ****************
  // Answer stream
  // ****************
  busy_after_read_a: assert property (take && cmd_code == 8'h23 |=> !cmd_ready)
    else $error("ready stayed high after a read was taken");
  first_item_a: assert property (take && cmd_code == 8'h33 |-> ##2 out_valid)
    else $error("no answer item two cycles after an extended read");
  abort_single_a: assert property (out_valid && out_error |-> out_last && !out_has_status)
    else $error("abort item not flagged last or carries status");
  abort_code_a: assert property (out_valid && out_error |->
    out_status == 8'h0F || out_status == 8'h10 || out_status == 8'h15)
    else $error("abort item with unknown code");
  area_one_tag_a: assert property (out_valid && out_has_status && !out_error &&
    out_block[15:3] <= area_one_end |-> out_status[6:5] == 2'h0)
    else $error("block inside area one reported in another area");
  area_beyond_a: assert property (out_valid && out_has_status && !out_error &&
    out_block[15:3] > area_one_end |-> out_status[6:5] != 2'h0)
    else $error("block past area one reported in area one");
  stall_hold_a: assert property (out_valid && !out_ready |=>
    out_valid && $stable(out_block) && $stable(out_status))
    else $error("item changed or vanished during a stall");
  // ****************
  // Sessions
  // ****************
  host_wr_reject_a: assert property (host_write_valid && !host_present_valid &&
    !host_session_open_status |=> host_write_rejected)
    else $error("host password write not refused with session closed");
  host_hold_a: assert property (!host_present_valid |=> $stable(host_session_open_status))
    else $error("host session changed without a present command");
  bad_number_a: assert property (take && cmd_code == 8'hB3 && cmd_pwd_num > 8'h03 |=>
    !rf_user_session_open && !rf_cfg_session_open && rf_pwd_rejected)
    else $error("unknown password number left a session open");
  rf_hold_a: assert property (!(take && cmd_code == 8'hB3) |=>
    $stable(rf_user_session_open) && $stable(rf_cfg_session_open))
    else $error("contactless session changed without a present command");
  cfg_no_session_a: assert property (cfg_wr_valid && !(cfg_wr_from_host ?
    host_session_open_status : rf_cfg_session_open) |=> cfg_wr_rejected)
    else $error("configuration write accepted without a session");
  cover property (take && cmd_code == 8'h3C);
  cover property (out_valid && out_error && out_status == 8'h0F);
  cover property (out_valid && !out_ready);
endmodule // area_protection_monitor

bind area_protection area_protection_monitor #(.END_W(END_W)) u_area_protection_monitor (
  .clk, .rstn, .cmd_valid, .cmd_ready, .cmd_code, .cmd_pwd_num, .out_valid, .out_ready,
  .out_block, .out_status, .out_has_status, .out_error, .out_last, .host_present_valid,
  .host_write_valid, .host_write_rejected, .host_session_open_status, .cfg_wr_valid,
  .cfg_wr_from_host, .cfg_wr_rejected, .rf_pwd_rejected, .rf_user_session_open,
  .rf_cfg_session_open, .area_one_end
);

// file: area_protection_tb.sv
// Testbench for area_protection: reads, aborts, areas and password sessions.
// Assumes area_protection.v, reader_sink.sv and the monitor are compiled first.
module area_protection_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rstn = 1'b0, slow = 1'b0, cmd_valid = 1'b0, cmd_option = 1'b0;
  logic [7:0] cmd_code = 8'h00, cmd_pwd_num = 8'h00, cfg_wr_data = 8'h00;
  logic [15:0] cmd_first = 16'h0000, cmd_count = 16'h0000;
  logic [15:0] rf_wr_block = 16'h0000, host_block = 16'h0000;
  logic [63:0] cmd_pwd = 64'h0, host_present_pwd = 64'h0, host_write_pwd = 64'h0;
  logic host_present_valid = 1'b0, host_write_valid = 1'b0, host_is_write = 1'b0;
  logic cfg_wr_valid = 1'b0, cfg_wr_from_host = 1'b0;
  logic [3:0] cfg_wr_sel = 4'h0;
  wire cmd_ready, out_valid, out_ready, out_has_status, out_error, out_last;
  wire [15:0] out_block, cnt, lblk;
  wire [7:0] out_status, lsts, area_one_end, area_two_end, area_three_end;
  wire lerr, lhas, llast, host_write_rejected, host_session_open_status;
  wire cfg_wr_rejected, rf_pwd_rejected, rf_user_session_open, rf_cfg_session_open;
  wire rf_wr_allowed, host_access_allowed;
  int err_count = 0;
  int tests_run = 0;
  always #25 clk = ~clk;
  area_protection #(.MEM_BLOCKS(2048), .END_W(8)) u_area_protection (
    .clk, .rstn, .cmd_valid, .cmd_ready, .cmd_code, .cmd_option, .cmd_first, .cmd_count,
    .cmd_pwd_num, .cmd_pwd, .out_valid, .out_ready, .out_block, .out_status, .out_has_status,
    .out_error, .out_last, .host_present_valid, .host_present_pwd, .host_write_valid,
    .host_write_pwd, .host_write_rejected, .host_session_open_status, .cfg_wr_valid,
    .cfg_wr_from_host, .cfg_wr_sel, .cfg_wr_data, .cfg_wr_rejected, .rf_pwd_rejected,
    .rf_user_session_open, .rf_cfg_session_open, .rf_wr_block, .rf_wr_allowed, .host_block,
    .host_is_write, .host_access_allowed, .area_one_end, .area_two_end, .area_three_end);
  reader_sink u_reader_sink (.clk, .rstn, .slow, .out_valid, .out_block, .out_status,
    .out_has_status, .out_error, .out_last, .out_ready, .cnt, .lblk, .lsts, .lerr, .lhas,
    .llast);
  // ****************
  // Shared tasks
  // ****************
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] c, input logic o, input logic [15:0] f, n,
      input logic [7:0] pn, input logic [63:0] pw);
    int i;
    @(negedge clk);
    cmd_code = c;
    cmd_option = o;
    cmd_first = f;
    cmd_count = n;
    cmd_pwd_num = pn;
    cmd_pwd = pw;
    cmd_valid = 1'b1;
    for (i = 0; i < 100 && cmd_ready !== 1'b1; i++) @(negedge clk);
    chk(cmd_ready, 1'b1);
    @(negedge clk);
    cmd_valid = 1'b0;
  endtask
  task automatic rd(input logic [7:0] c, input logic o, input logic [15:0] f, n, items,
      input logic [7:0] e);
    logic [15:0] base;
    int i;
    base = cnt;
    cmd(c, o, f, n, 8'h00, 64'h0);
    for (i = 0; i < 3000 && cnt != base + items; i++) @(negedge clk);
    chk(cnt - base, items);
    chk({lerr, llast}, {e != 8'h00, 1'b1});
    chk(lhas, e == 8'h00 && (o || c == 8'h2C || c == 8'h3C));
    if (e != 8'h00) chk(lsts, e);
    else chk(lblk, f + n);
  endtask
  task automatic cfg(input logic h, input logic [3:0] s, input logic [7:0] d, input logic rej);
    @(negedge clk);
    cfg_wr_valid = 1'b1;
    cfg_wr_from_host = h;
    cfg_wr_sel = s;
    cfg_wr_data = d;
    @(negedge clk);
    cfg_wr_valid = 1'b0;
    chk(cfg_wr_rejected, rej);
  endtask
  task automatic hst(input logic w, input logic [63:0] p);
    @(negedge clk);
    host_write_valid = w;
    host_present_valid = !w;
    host_write_pwd = p;
    host_present_pwd = p;
    @(negedge clk);
    host_write_valid = 1'b0;
    host_present_valid = 1'b0;
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic s_reset;
    chk({area_one_end, area_three_end}, 16'hFFFF);
    chk({rf_user_session_open, rf_cfg_session_open, host_session_open_status}, 3'h0);
  endtask
  task automatic s_reads;
    slow = 1'b1;
    rd(8'h23, 1'b0, 16'h0005, 16'h0001, 16'h0002, 8'h00);
    rd(8'hC3, 1'b1, 16'h0000, 16'h00FF, 16'h0100, 8'h00);
    rd(8'h33, 1'b0, 16'h012C, 16'h0002, 16'h0003, 8'h00);
    rd(8'hC5, 1'b1, 16'h07FE, 16'h0001, 16'h0002, 8'h00);
    rd(8'h2C, 1'b0, 16'h00F0, 16'h000F, 16'h0010, 8'h00);
    rd(8'h3C, 1'b0, 16'h01F0, 16'h0003, 16'h0004, 8'h00);
    slow = 1'b0;
    rd(8'h23, 1'b0, 16'h00F8, 16'h0008, 16'h0001, 8'h10);
    rd(8'h2C, 1'b0, 16'h00FF, 16'h0001, 16'h0001, 8'h10);
    rd(8'h33, 1'b0, 16'h07FC, 16'h0004, 16'h0001, 8'h10);
  endtask
  task automatic s_areas;
    cmd(8'hB3, 1'b0, 16'h0000, 16'h0000, 8'h00, 64'h0);
    chk(rf_cfg_session_open, 1'b1);
    cfg(1'b0, 4'h1, 8'h00, 1'b0);
    chk(area_one_end, 8'h00);
    cfg(1'b0, 4'h2, 8'h00, 1'b1);
    chk(area_two_end, 8'hFF);
    cfg(1'b0, 4'h5, 8'h09, 1'b0);
    cfg(1'b0, 4'h4, 8'h0D, 1'b0);
    rd(8'h33, 1'b0, 16'h0006, 16'h0003, 16'h0001, 8'h0F);
    rd(8'h3C, 1'b0, 16'h0006, 16'h0003, 16'h0004, 8'h00);
    chk(lsts, 8'h29);
    cmd(8'hB3, 1'b0, 16'h0000, 16'h0000, 8'h01, 64'h5);
    chk({rf_pwd_rejected, rf_cfg_session_open}, 2'h2);
    cfg(1'b0, 4'h2, 8'hFF, 1'b1);
    rf_wr_block = 16'h0008;
    rd(8'h23, 1'b0, 16'h0008, 16'h0000, 16'h0001, 8'h15);
    chk(rf_wr_allowed, 1'b0);
    rd(8'h23, 1'b0, 16'h0000, 16'h0000, 16'h0001, 8'h00);
    cmd(8'hB3, 1'b0, 16'h0000, 16'h0000, 8'h01, 64'h0);
    chk(rf_user_session_open, 1'b1);
    rd(8'h23, 1'b0, 16'h0008, 16'h0000, 16'h0001, 8'h00);
    chk(rf_wr_allowed, 1'b1);
    // Password change: present the current value first, then write the same number
    cmd(8'hB1, 1'b0, 16'h0000, 16'h0000, 8'h01, 64'hA5);
    chk(rf_pwd_rejected, 1'b0);
    cmd(8'hB1, 1'b0, 16'h0000, 16'h0000, 8'h02, 64'hA5);
    chk(rf_pwd_rejected, 1'b1);
    cmd(8'hB3, 1'b0, 16'h0000, 16'h0000, 8'h01, 64'hA5);
    chk(rf_user_session_open, 1'b1);
    cmd(8'hB3, 1'b0, 16'h0000, 16'h0000, 8'h04, 64'hA5);
    chk({rf_pwd_rejected, rf_user_session_open}, 2'h2);
  endtask
  task automatic s_host;
    host_block = 16'h0008;
    hst(1'b1, 64'h7);
    chk(host_write_rejected, 1'b1);
    hst(1'b0, 64'h0);
    chk(host_session_open_status, 1'b1);
    cfg(1'b1, 4'h8, 8'h0C, 1'b0);
    chk(host_access_allowed, 1'b1);
    hst(1'b1, 64'h7);
    chk(host_write_rejected, 1'b0);
    hst(1'b0, 64'h0);
    chk(host_session_open_status, 1'b0);
    chk(host_access_allowed, 1'b0);
    @(negedge clk);
    host_is_write = 1'b1;
    @(negedge clk);
    chk(host_access_allowed, 1'b0);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    s_reset;
    s_reads;
    s_areas;
    s_host;
    conclude;
  end
  // Whole run needs under a thousand cycles of the 40000 allowed; this leaves a wide margin
  initial begin
    #2000000;
    err_count++;
    conclude;
  end
endmodule // area_protection_tb

// file: reader_sink.sv
// Downstream reader model: takes answer items and remembers the latest one.
// Assumes items stay stable while out_ready is low; slow stalls every other cycle.
module reader_sink (
  input logic clk,
  input logic rstn,
  input logic slow,
  input logic out_valid,
  input logic [15:0] out_block,
  input logic [7:0] out_status,
  input logic out_has_status,
  input logic out_error,
  input logic out_last,
  output logic out_ready,
  output logic [15:0] cnt,
  output logic [15:0] lblk,
  output logic [7:0] lsts,
  output logic lerr,
  output logic lhas,
  output logic llast
);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      out_ready <= 1'b0;
      cnt <= 16'h0000;
    end else begin
      // Stalling exercises the two-entry buffer without losing words
      out_ready <= slow ? ~out_ready : 1'b1;
      if (out_valid && out_ready) begin
        cnt <= cnt + 16'h0001;
        lblk <= out_block;
        lsts <= out_status;
        lerr <= out_error;
        lhas <= out_has_status;
        llast <= out_last;
      end
    end
  end
endmodule // reader_sink
